/* File: design/tmr_pkg.sv */
package tmr_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NCH = 3;
  localparam int CW = 16;
  localparam int PHASE_CH = 2;
  localparam int SYNC_W = 8;

  // ----------------------------------------------------------------
  // Register map: address[6:5] selects a channel bank (3 is the global bank), address[4:2] the word.
  // ----------------------------------------------------------------
  localparam logic [1:0] GLOBAL_BANK = 2'h3;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_PIN = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_COUNT = 3'h3;
  localparam logic [2:0] REG_GRA = 3'h4;
  localparam logic [2:0] REG_GRB = 3'h5;
  localparam logic [2:0] REG_START = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_LOCK = 3'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CLK_LSB = 0;
  localparam int CTRL_CLR_LSB = 4;
  localparam int PIN_IOA_LSB = 0;
  localparam int PIN_IOB_LSB = 4;
  localparam int PIN_SEL_BIT = 2;
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 1;
  localparam int FLAG_WRAP = 2;
  localparam int MODE_PULSE_LSB = 0;
  localparam int MODE_QUAD_BIT = 6;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] PIN_RST = 8'h00;

  typedef enum logic [1:0] {BUS_T1, BUS_T2, BUS_T3} tmr_bus_e;

  typedef struct packed {
    tmr_bus_e bus;
    logic [31:0] rdata;
    logic [2:0] div;
    logic [NCH-1:0][CW-1:0] count;
    logic [NCH-1:0][CW-1:0] general_reg_a;
    logic [NCH-1:0][CW-1:0] general_reg_b;
    logic [NCH-1:0][5:0] ctrl;
    logic [NCH-1:0][7:0] pin;
    logic [NCH-1:0][2:0] flag;
    logic [NCH-1:0][2:0] armed;
    logic [NCH-1:0] start;
    logic [NCH-1:0] lock;
    logic [NCH-1:0] pulse;
    logic quad;
    logic [NCH-1:0] pwm;
  } tmr_state_s;

endpackage : tmr_pkg

/* File: design/tmr_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module tmr_pin_sync #(
  parameter int W = 8
) (
  input wire logic clock_i, // System clock.
  input wire logic nrst_i, // Synchronous reset, active low.
  input wire logic [W-1:0] pin_i, // Asynchronous pin levels.
  output logic [W-1:0] level_o, // Synchronised level.
  output logic [W-1:0] rise_o, // One-cycle pulse on a rising edge.
  output logic [W-1:0] fall_o // One-cycle pulse on a falling edge.
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] last;
  } tmr_sync_s;

  tmr_sync_s s_reg;
  tmr_sync_s s_next;

  always_comb begin
    s_next.meta = pin_i;
    s_next.sync = s_reg.meta;
    s_next.last = s_reg.sync;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection looks only at the second and third stages.
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign level_o[i] = s_reg.sync[i];
    assign rise_o[i] = s_reg.sync[i] & ~s_reg.last[i];
    assign fall_o[i] = ~s_reg.sync[i] & s_reg.last[i];
  end

endmodule : tmr_pin_sync

`default_nettype wire

/* File: design/tmr_core.sv */
`timescale 1ns/1ns
`default_nettype none

module tmr_core (
  input wire logic clock_i, // System clock, 125 MHz.
  input wire logic nrst_i, // Synchronous reset, active low.
  input wire logic [7:0] avs_address_i, // Avalon byte address.
  input wire logic avs_read_i, // Avalon read request.
  input wire logic avs_write_i, // Avalon write request.
  input wire logic [31:0] avs_writedata_i, // Avalon write data.
  input wire logic [3:0] avs_byteenable_i, // Avalon byte enables.
  output logic [31:0] avs_readdata_o, // Avalon read data.
  output logic avs_waitrequest_o, // Avalon wait request.
  input wire logic [2:0] capture_a_i, // Capture pins A per channel.
  input wire logic [2:0] capture_b_i, // Capture pins B per channel.
  input wire logic phase_input_a_i, // Quadrature input A.
  input wire logic phase_input_b_i, // Quadrature input B.
  output logic [2:0] pwm_o, // Pulse-mode outputs per channel.
  output logic [2:0] match_capture_flag_a_o, // Flag A per channel.
  output logic [2:0] match_capture_flag_b_o, // Flag B per channel.
  output logic [2:0] wrap_flag_o // Wrap flag per channel.
);

  tmr_pkg::tmr_state_s s_reg;
  tmr_pkg::tmr_state_s s_next;

  logic [tmr_pkg::SYNC_W-1:0] pin_lvl;
  logic [tmr_pkg::SYNC_W-1:0] pin_rise;
  logic [tmr_pkg::SYNC_W-1:0] pin_fall;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  tmr_pin_sync #(
    .W(tmr_pkg::SYNC_W)
  ) u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .pin_i({phase_input_b_i, phase_input_a_i, capture_b_i, capture_a_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    return (sel[0] & r) | (sel[1] & f);
  endfunction : edge_hit

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic req;
    logic t2;
    logic t3;
    logic wr;
    logic chan_hit;
    logic [1:0] ch;
    logic [2:0] rsel;
    logic byte_wr;
    logic [15:0] merged;
    logic [3:0] ticks;
    logic lvl_a;
    logic lvl_b;
    logic q_up;
    logic q_dn;
    logic sync_clr;
    logic [2:0] inc;
    logic [2:0] up;
    logic [2:0] targeted;
    logic [2:0] cnt_wr;
    logic [2:0] inhibit;
    logic [2:0] cap_a;
    logic [2:0] cap_b;
    logic [2:0] m_a;
    logic [2:0] m_b;
    logic [2:0] own_clr;
    logic [2:0] set;
    logic [2:0] clr_bits;
    logic clr;
    logic [2:0] ioa;
    logic [2:0] iob;
    logic [1:0] src;
    logic [31:0] rd;
    s_next = s_reg;
    req = avs_read_i | avs_write_i;
    t2 = req && (s_reg.bus == tmr_pkg::BUS_T2);
    t3 = req && (s_reg.bus == tmr_pkg::BUS_T3);
    wr = avs_write_i && t3;
    chan_hit = avs_address_i[6:5] != tmr_pkg::GLOBAL_BANK;
    ch = chan_hit ? avs_address_i[6:5] : 2'h0;
    rsel = avs_address_i[4:2];
    byte_wr = avs_byteenable_i[1:0] != 2'h3;
    merged = s_reg.count[ch];
    if (avs_byteenable_i[0]) begin
      merged[7:0] = avs_writedata_i[7:0];
    end
    if (avs_byteenable_i[1]) begin
      merged[15:8] = avs_writedata_i[15:8];
    end
    sync_clr = 1'b0;
    rd = 32'h0000_0000;
    set = 3'h0;
    clr_bits = 3'h0;
    clr = 1'b0;
    ioa = 3'h0;
    iob = 3'h0;
    src = 2'h0;
    s_next.div = s_reg.div + 3'h1;
    ticks = {&s_reg.div, &s_reg.div[1:0], s_reg.div[0], 1'b1};
    lvl_a = pin_lvl[6];
    lvl_b = pin_lvl[7];
    q_up = (pin_rise[7] & ~lvl_a) | (pin_rise[6] & lvl_b) | (pin_fall[7] & lvl_a) | (pin_fall[6] & ~lvl_b);
    q_dn = (pin_fall[6] & lvl_b) | (pin_fall[7] & ~lvl_a) | (pin_rise[6] & ~lvl_b) | (pin_rise[7] & lvl_a);
    inc = 3'h0;
    up = 3'h0;
    targeted = 3'h0;
    cnt_wr = 3'h0;
    inhibit = 3'h0;
    cap_a = 3'h0;
    cap_b = 3'h0;
    m_a = 3'h0;
    m_b = 3'h0;
    own_clr = 3'h0;

    // Three-state bus cycle; the master holds the request through T3.
    case (s_reg.bus)
      tmr_pkg::BUS_T1: begin
        if (req) begin
          s_next.bus = tmr_pkg::BUS_T2;
        end
      end
      tmr_pkg::BUS_T2: begin
        s_next.bus = tmr_pkg::BUS_T3;
      end
      tmr_pkg::BUS_T3: begin
        s_next.bus = tmr_pkg::BUS_T1;
      end
      default: begin
        s_next.bus = tmr_pkg::BUS_T1;
      end
    endcase

    // ----------------------------------------------------------------
    // Per-channel events
    // ----------------------------------------------------------------
    for (int c = 0; c < tmr_pkg::NCH; c++) begin
      ioa = s_reg.pin[c][tmr_pkg::PIN_IOA_LSB +: 3];
      iob = s_reg.pin[c][tmr_pkg::PIN_IOB_LSB +: 3];
      src = s_reg.ctrl[c][tmr_pkg::CTRL_CLR_LSB +: 2];
      if (s_reg.quad && c == tmr_pkg::PHASE_CH) begin
        inc[c] = s_reg.start[c] && (q_up || q_dn);
        up[c] = q_up;
      end else begin
        inc[c] = s_reg.start[c] && ticks[s_reg.ctrl[c][tmr_pkg::CTRL_CLK_LSB +: 2]];
        up[c] = 1'b1;
      end
      // A write to any lockstep counter lands in every lockstep counter.
      targeted[c] = chan_hit && rsel == tmr_pkg::REG_COUNT
        && (ch == c[1:0] || (s_reg.lock[c] && s_reg.lock[ch]));
      cnt_wr[c] = wr && targeted[c];
      inhibit[c] = cnt_wr[c] || (avs_write_i && t2 && byte_wr && targeted[c]);
      cap_a[c] = !s_reg.pulse[c] && ioa[tmr_pkg::PIN_SEL_BIT]
        && edge_hit(ioa[1:0], pin_rise[c], pin_fall[c]);
      cap_b[c] = !s_reg.pulse[c] && iob[tmr_pkg::PIN_SEL_BIT]
        && edge_hit(iob[1:0], pin_rise[3 + c], pin_fall[3 + c]);
      // Match is taken on the count that is about to be left behind.
      m_a[c] = inc[c] && s_reg.count[c] == s_reg.general_reg_a[c]
        && (s_reg.pulse[c] || !ioa[tmr_pkg::PIN_SEL_BIT]);
      m_b[c] = inc[c] && s_reg.count[c] == s_reg.general_reg_b[c]
        && (s_reg.pulse[c] || !iob[tmr_pkg::PIN_SEL_BIT]);
      if (wr && chan_hit && ch == c[1:0] && rsel == tmr_pkg::REG_GRA) begin
        m_a[c] = 1'b0;
      end
      if (wr && chan_hit && ch == c[1:0] && rsel == tmr_pkg::REG_GRB) begin
        m_b[c] = 1'b0;
      end
      if (s_reg.pulse[c] && m_a[c] && m_b[c]) begin
        m_a[c] = 1'b0;
        m_b[c] = 1'b0;
      end
      own_clr[c] = (src == tmr_pkg::CLR_A && (m_a[c] || cap_a[c]))
        || (src == tmr_pkg::CLR_B && (m_b[c] || cap_b[c]));
      if (s_reg.lock[c] && own_clr[c]) begin
        sync_clr = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Per-channel updates; each contention pair is settled on its own.
    // ----------------------------------------------------------------
    for (int c = 0; c < tmr_pkg::NCH; c++) begin
      src = s_reg.ctrl[c][tmr_pkg::CTRL_CLR_LSB +: 2];
      clr = own_clr[c] || (src == tmr_pkg::CLR_SYNC && s_reg.lock[c] && sync_clr);
      if (clr) begin
        s_next.count[c] = tmr_pkg::COUNT_ZERO;
      end else if (cnt_wr[c]) begin
        s_next.count[c] = merged;
      end else if (inc[c] && !inhibit[c]) begin
        s_next.count[c] = up[c] ? s_reg.count[c] + 16'h0001 : s_reg.count[c] - 16'h0001;
      end
      // The general register keeps the count from before any clear.
      if (cap_a[c]) begin
        s_next.general_reg_a[c] = s_reg.count[c];
      end else if (wr && chan_hit && ch == c[1:0] && rsel == tmr_pkg::REG_GRA) begin
        s_next.general_reg_a[c] = avs_writedata_i[15:0];
      end
      if (cap_b[c]) begin
        s_next.general_reg_b[c] = s_reg.count[c];
      end else if (wr && chan_hit && ch == c[1:0] && rsel == tmr_pkg::REG_GRB) begin
        s_next.general_reg_b[c] = avs_writedata_i[15:0];
      end
      set[tmr_pkg::FLAG_A] = m_a[c] || cap_a[c];
      set[tmr_pkg::FLAG_B] = m_b[c] || cap_b[c];
      set[tmr_pkg::FLAG_WRAP] = inc[c]
        && (up[c] ? s_reg.count[c] == tmr_pkg::COUNT_MAX : s_reg.count[c] == tmr_pkg::COUNT_ZERO);
      clr_bits = 3'h0;
      if (wr && chan_hit && ch == c[1:0] && rsel == tmr_pkg::REG_STATUS) begin
        clr_bits = ~avs_writedata_i[2:0] & s_reg.armed[c];
      end
      if (avs_read_i && t3 && chan_hit && ch == c[1:0] && rsel == tmr_pkg::REG_STATUS) begin
        s_next.armed[c] = s_reg.armed[c] | s_reg.rdata[2:0];
      end
      s_next.armed[c] = s_next.armed[c] & ~clr_bits;
      // A new event in the clearing cycle keeps the flag set.
      s_next.flag[c] = (s_reg.flag[c] & ~clr_bits) | set;
      if (s_reg.pulse[c]) begin
        if (m_a[c]) begin
          s_next.pwm[c] = 1'b1;
        end else if (m_b[c]) begin
          s_next.pwm[c] = 1'b0;
        end
      end
    end

    // ----------------------------------------------------------------
    // Plain register writes
    // ----------------------------------------------------------------
    if (wr) begin
      if (chan_hit) begin
        if (rsel == tmr_pkg::REG_CTRL) begin
          s_next.ctrl[ch] = avs_writedata_i[5:0];
        end else if (rsel == tmr_pkg::REG_PIN) begin
          s_next.pin[ch] = avs_writedata_i[7:0];
        end
      end else if (rsel == tmr_pkg::REG_START) begin
        s_next.start = avs_writedata_i[2:0];
      end else if (rsel == tmr_pkg::REG_MODE) begin
        s_next.pulse = avs_writedata_i[tmr_pkg::MODE_PULSE_LSB +: 3];
        s_next.quad = avs_writedata_i[tmr_pkg::MODE_QUAD_BIT];
      end else if (rsel == tmr_pkg::REG_LOCK) begin
        s_next.lock = avs_writedata_i[2:0];
      end
    end

    // ----------------------------------------------------------------
    // Read data is latched at the end of T2 so a capture in T3 is not seen.
    // ----------------------------------------------------------------
    if (chan_hit) begin
      case (rsel)
        tmr_pkg::REG_CTRL: rd[5:0] = s_reg.ctrl[ch];
        tmr_pkg::REG_PIN: rd[7:0] = s_reg.pin[ch];
        tmr_pkg::REG_STATUS: rd[2:0] = s_reg.flag[ch];
        tmr_pkg::REG_COUNT: rd[15:0] = s_reg.count[ch];
        tmr_pkg::REG_GRA: rd[15:0] = s_reg.general_reg_a[ch];
        tmr_pkg::REG_GRB: rd[15:0] = s_reg.general_reg_b[ch];
        default: rd = 32'h0000_0000;
      endcase
    end else begin
      case (rsel)
        tmr_pkg::REG_START: rd[2:0] = s_reg.start;
        tmr_pkg::REG_MODE: rd[7:0] = {1'b0, s_reg.quad, 3'h0, s_reg.pulse};
        tmr_pkg::REG_LOCK: rd[2:0] = s_reg.lock;
        default: rd = 32'h0000_0000;
      endcase
    end
    if (avs_read_i && t2) begin
      s_next.rdata = rd;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      s_reg.bus <= tmr_pkg::BUS_T1;
      s_reg.rdata <= 32'h0000_0000;
      s_reg.div <= 3'h0;
      s_reg.count <= {tmr_pkg::NCH{tmr_pkg::COUNT_RST}};
      s_reg.general_reg_a <= {tmr_pkg::NCH{tmr_pkg::GR_RST}};
      s_reg.general_reg_b <= {tmr_pkg::NCH{tmr_pkg::GR_RST}};
      s_reg.ctrl <= {tmr_pkg::NCH{tmr_pkg::CTRL_RST}};
      s_reg.pin <= {tmr_pkg::NCH{tmr_pkg::PIN_RST}};
      s_reg.flag <= '0;
      s_reg.armed <= '0;
      s_reg.start <= 3'h0;
      s_reg.lock <= 3'h0;
      s_reg.pulse <= 3'h0;
      s_reg.quad <= 1'b0;
      s_reg.pwm <= 3'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) && s_reg.bus != tmr_pkg::BUS_T3;
  assign avs_readdata_o = s_reg.rdata;
  assign pwm_o = s_reg.pwm;
  for (genvar c = 0; c < tmr_pkg::NCH; c++) begin : g_flag
    assign match_capture_flag_a_o[c] = s_reg.flag[c][tmr_pkg::FLAG_A];
    assign match_capture_flag_b_o[c] = s_reg.flag[c][tmr_pkg::FLAG_B];
    assign wrap_flag_o[c] = s_reg.flag[c][tmr_pkg::FLAG_WRAP];
  end

endmodule : tmr_core

`default_nettype wire

/* File: tb/tmr_core_props.sv */
`timescale 1ns/1ns
`default_nettype none

module tmr_core_props (
  input wire logic clock_i, // System clock.
  input wire logic nrst_i, // Synchronous reset, active low.
  input wire logic [7:0] avs_address_i, // Byte address.
  input wire logic avs_read_i, // Read request.
  input wire logic avs_write_i, // Write request.
  input wire logic [31:0] avs_readdata_o, // Read data.
  input wire logic avs_waitrequest_o, // Wait request.
  input wire logic [2:0] pwm_o, // Pulse outputs.
  input wire logic [2:0] match_capture_flag_a_o, // Flag A.
  input wire logic [2:0] match_capture_flag_b_o, // Flag B.
  input wire logic [2:0] wrap_flag_o // Wrap flag.
);
  // ----------------------------------------------------------------
  // Bus and flag checks
  // ----------------------------------------------------------------
  logic req;
  logic rd_end;
  logic st_hit;
  assign req = avs_read_i | avs_write_i;
  assign rd_end = avs_read_i & ~avs_waitrequest_o;
  assign st_hit = avs_address_i[6:2] == {2'h0, tmr_pkg::REG_STATUS};

  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  three_state_a: assert property (
    req && !$past(req && avs_waitrequest_o) |-> avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("Bus cycle did not take three states.");
  idle_ready_a: assert property (
    !req |-> !avs_waitrequest_o)
    else $error("Wait request raised while idle.");
  upper_zero_a: assert property (
    rd_end |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("Unused read data bits not zero.");
  hole_zero_a: assert property (
    rd_end && avs_address_i[6:5] != 2'h3 && avs_address_i[4:3] == 2'h3 |-> avs_readdata_o == 32'h0000_0000)
    else $error("Unmapped word did not read zero.");
  status_read_a: assert property (
    rd_end && st_hit |-> avs_readdata_o[2:0] == $past({wrap_flag_o[0], match_capture_flag_b_o[0],
                                                        match_capture_flag_a_o[0]}))
    else $error("Status read does not show the flags.");
  data_hold_a: assert property (
    rd_end |=> $stable(avs_readdata_o))
    else $error("Read data moved after the read.");
  wrap_clear_a: assert property (
    $fell(wrap_flag_o[0]) |-> $past(avs_write_i && !avs_waitrequest_o && st_hit))
    else $error("Wrap flag cleared without a status write.");
  pwm_set_a: assert property (
    $rose(pwm_o[0]) |-> match_capture_flag_a_o[0])
    else $error("Pulse output rose without match A.");
endmodule : tmr_core_props

bind tmr_core tmr_core_props i_props (.clock_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .pwm_o, .match_capture_flag_a_o, .match_capture_flag_b_o, .wrap_flag_o);

`default_nettype wire

/* File: tb/tmr_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none

module tmr_cpu_model (
  input wire logic clock_i, // System clock.
  input wire logic waitrequest_i, // Slave stall.
  input wire logic [31:0] readdata_i, // Slave read data.
  output logic [7:0] address_o, // Byte address.
  output logic read_o, // Read strobe.
  output logic write_o, // Write strobe.
  output logic [31:0] writedata_o, // Write data.
  output logic [3:0] byteenable_o // Byte enables.
);
  initial begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0000_0000;
    byteenable_o = 4'h0;
  end

  // Released address and write data lines carry the inverse of their last value, so a slave cannot lean on stale data.
  task automatic access(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] e,
                        output logic [31:0] q);
    @(posedge clock_i);
    address_o <= a;
    writedata_o <= d;
    byteenable_o <= e;
    read_o <= !w;
    write_o <= w;
    @(posedge clock_i);
    while (waitrequest_i !== 1'b0) @(posedge clock_i);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    address_o <= ~a;
    writedata_o <= ~d;
  endtask : access
endmodule : tmr_cpu_model

`default_nettype wire

/* File: tb/tb_timer16_contention_and_modes.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_timer16_contention_and_modes;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr;
  logic rd_s;
  logic wr_s;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] be;
  logic wait_s;
  logic [2:0] cap_a = 3'h0;
  logic [2:0] cap_b = 3'h0;
  logic ph_a = 1'b0;
  logic ph_b = 1'b0;
  logic [2:0] pwm;
  logic [2:0] flag_a;
  logic [2:0] flag_b;
  logic [2:0] flag_w;
  logic [31:0] got;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [7:0] rst_addr [5] = '{8'h0C, 8'h10, 8'h14, 8'h00, 8'h1C};
  logic [31:0] rst_val [5] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0};
  // Four quadrature steps up, then five down, so the count ends one below zero.
  logic [1:0] steps [9] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0, 2'h2};

  always #4 clock = ~clock;

  tmr_core i_dut (.clock_i(clock), .nrst_i(nrst), .avs_address_i(addr), .avs_read_i(rd_s), .avs_write_i(wr_s),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s),
    .capture_a_i(cap_a), .capture_b_i(cap_b), .phase_input_a_i(ph_a), .phase_input_b_i(ph_b), .pwm_o(pwm),
    .match_capture_flag_a_o(flag_a), .match_capture_flag_b_o(flag_b), .wrap_flag_o(flag_w));

  tmr_cpu_model i_cpu (.clock_i(clock), .waitrequest_i(wait_s), .readdata_i(rdata), .address_o(addr),
    .read_o(rd_s), .write_o(wr_s), .writedata_o(wdata), .byteenable_o(be));

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    n_checks++;
    if (seen !== expected) begin
      n_mismatch++;
      $display("BAD %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] e = 4'hF);
    i_cpu.access(a, 1'b1, d, e, got);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] expected);
    i_cpu.access(a, 1'b0, 32'h0, 4'hF, got);
    check(got, expected);
  endtask : rd_chk

  task automatic cap_rise();
    @(posedge clock);
    cap_a[2] <= 1'b0;
    repeat (4) @(posedge clock);
    cap_a[2] <= 1'b1;
    repeat (6) @(posedge clock);
  endtask : cap_rise

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) rd_chk(rst_addr[i], rst_val[i]);
    // Counting every clock makes each counter write meet an increment in its commit state.
    wr(8'h60, 32'h1);
    wr(8'h0C, 32'hFFFF);
    rd_chk(8'h0C, 32'h1);
    @(negedge clock);
    check({29'h0, flag_w}, 32'h1);
    // Outside pulse mode equal general registers both flag when the count leaves FFFF.
    check({26'h0, flag_b, flag_a}, 32'h9);
    wr(8'h08, 32'h0);
    @(negedge clock);
    check({29'h0, flag_w}, 32'h1);
    rd_chk(8'h08, 32'h7);
    wr(8'h08, 32'h0);
    @(negedge clock);
    check({29'h0, flag_w}, 32'h0);
    wr(8'h0C, 32'h55, 4'h1);
    rd_chk(8'h0C, 32'h57);
    wr(8'h0C, 32'h1200, 4'h2);
    rd_chk(8'h0C, 32'h125D);
    wr(8'h64, 32'h1);
    for (int s = 1; s < 3; s++) begin
      wr(8'h10, s == 1 ? 32'h4 : 32'hFFFF);
      wr(8'h14, s == 1 ? 32'hFFFF : 32'h4);
      wr(8'h00, 32'(s) << 4);
      wr(8'h0C, 32'h0);
      for (int i = 0; i < 4; i++) rd_chk(8'h0C, (2 + 4 * i) % 5);
      @(negedge clock);
      check({31'h0, s == 1 ? flag_a[0] : flag_b[0]}, 32'h1);
      check({31'h0, pwm[0]}, s == 1 ? 32'h1 : 32'h0);
    end
    // In pulse mode equal GENERAL_REG_A and GENERAL_REG_B cancel both matches, so the clear on B never comes.
    wr(8'h10, 32'h4);
    rd_chk(8'h0C, 32'h2);
    rd_chk(8'h0C, 32'h6);
    @(negedge clock);
    check({31'h0, pwm[0]}, 32'h0);
    // A distinct high byte in channel 1 shows whether the lockstep write copies all 16 bits.
    wr(8'h2C, 32'h3400);
    wr(8'h68, 32'h3);
    wr(8'h10, 32'h4);
    wr(8'h14, 32'hFFFF);
    wr(8'h00, 32'h10);
    wr(8'h20, 32'h30);
    wr(8'h60, 32'h3);
    wr(8'h0C, 32'h0, 4'h1);
    for (int i = 0; i < 3; i++) rd_chk(8'h2C, (2 + 4 * i) % 5);
    wr(8'h60, 32'h0);
    wr(8'h64, 32'h0);
    wr(8'h44, 32'h5);
    wr(8'h4C, 32'h1234);
    cap_rise();
    rd_chk(8'h50, 32'h1234);
    check({31'h0, flag_a[2]}, 32'h1);
    wr(8'h64, 32'h4);
    wr(8'h4C, 32'h0777);
    cap_rise();
    rd_chk(8'h50, 32'h1234);
    wr(8'h64, 32'h40);
    wr(8'h4C, 32'h0);
    wr(8'h60, 32'h4);
    for (int i = 0; i < 9; i++) begin
      @(posedge clock);
      {ph_a, ph_b} <= steps[i];
      repeat (4) @(posedge clock);
      if (i == 3) rd_chk(8'h4C, 32'h4);
    end
    rd_chk(8'h4C, 32'hFFFF);
    @(negedge clock);
    check({31'h0, flag_w[2]}, 32'h1);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_timer16_contention_and_modes

`default_nettype wire
